// File: logic/fspr_pkg.sv
package fspr_pkg;

	localparam logic [7:0] OP_SET_LATCH       = 8'h06;
	localparam logic [7:0] OP_SET_LATCH_VOL   = 8'h50;
	localparam logic [7:0] OP_CLEAR_LATCH     = 8'h04;
	localparam logic [7:0] OP_CLEAR_STATUS    = 8'h30;
	localparam logic [7:0] OP_WRITE_REGS      = 8'h01;
	localparam logic [7:0] OP_WRITE_ANY       = 8'h71;
	localparam logic [7:0] OP_READ_ANY        = 8'h65;
	localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
	localparam logic [7:0] OP_RESET_ARM       = 8'h66;
	localparam logic [7:0] OP_RESET_EXEC      = 8'h99;
	localparam logic [7:0] OP_SUSPEND         = 8'h75;
	localparam logic [7:0] OP_PROGRAM         = 8'h02;
	localparam logic [7:0] OP_ERASE_SECTOR    = 8'h20;
	localparam logic [7:0] OP_ERASE_BLOCK     = 8'hD8;
	localparam logic [7:0] OP_ERASE_CHIP      = 8'hC7;

	localparam logic [7:0] ANY_REG_NV_ADDR  = 8'h00;
	localparam logic [7:0] ANY_REG_VOL_ADDR = 8'h80;

	localparam int LOCK_POS        = 7;
	localparam int BOTTOM_POS      = 6;
	localparam int LEVEL_LSB       = 2;
	localparam int SMALL_GRAN_POS  = 6;
	localparam int SMALL_BOTTOM_POS = 5;
	localparam int LATCH_POS       = 1;
	localparam int BUSY_POS        = 0;

	localparam logic [3:0] LEVEL_RESET    = 4'h0;
	localparam logic [9:0] LINK_BIT_LIMIT = 10'h3FF;
	localparam logic [5:0] NBYTES_LIMIT   = 6'h3F;

	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int REG_WRITE_NS      = 1000;
	localparam int REG_WRITE_CYCLES  =
		(REG_WRITE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

	typedef struct packed {
		logic       lock;
		logic       granularity;
		logic       bottom;
		logic [3:0] level;
	} fspr_prot_type;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] arg0;
		logic [7:0] arg1;
		logic [5:0] nbytes;
	} fspr_frame_type;

	typedef struct packed {
		logic [7:0] live;
		logic [7:0] defaults;
	} fspr_snap_type;

	typedef struct packed {
		logic [7:0]     shift;
		fspr_frame_type frame;
	} fspr_link_type;

	typedef enum logic [1:0] {
		FSPR_IDLE,
		FSPR_REG_WRITE,
		FSPR_ARRAY_OP,
		FSPR_FAILED
	} fspr_mode_type;

	typedef struct packed {
		logic [1:0]     cs_sync;
		logic [1:0]     wp_sync;
		logic [1:0]     hw_sync;
		logic           cs_prev;
		logic           hw_prev;
		fspr_prot_type  vol;
		fspr_prot_type  nv;
		logic           write_enable_latch;
		logic           vol_target;
		logic           reset_armed;
		logic           locked;
		fspr_mode_type  mode;
		logic [15:0]    wait_cnt;
		logic           array_start;
		logic [7:0]     array_opcode;
		logic           suspend;
		fspr_snap_type  snap;
	} fspr_sys_type;

endpackage

// File: logic/fspr_link_shifter.sv
module fspr_link_shifter (
	input  wire logic                   i_sclk,
	input  wire logic                   i_cs_n,
	input  wire logic                   i_mosi,
	input  wire fspr_pkg::fspr_snap_type i_snapshot,
	output fspr_pkg::fspr_frame_type    o_frame,
	output logic                        o_miso,
	output logic                        o_miso_oe
);
	import fspr_pkg::*;

	logic [9:0]    bit_count;
	fspr_link_type st;
	fspr_link_type next_st;
	logic [7:0]    out_byte;
	logic          out_valid;

	// The select line clears the counter so no serial edge is needed
	// outside a frame; the clock may stand still between frames.
	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_count <= 10'h000;
		end else if (bit_count != LINK_BIT_LIMIT) begin
			bit_count <= bit_count + 10'h001;
		end
	end

	always_comb begin
		next_st = st;
		next_st.shift = {st.shift[6:0], i_mosi};
		if (bit_count == 10'h000) begin
			next_st.frame.nbytes = 6'h00;
		end
		if (bit_count[2:0] == 3'h7) begin
			if (bit_count[9:3] == 7'h00) begin
				next_st.frame.opcode = next_st.shift;
			end else if (bit_count[9:3] == 7'h01) begin
				next_st.frame.arg0 = next_st.shift;
			end else if (bit_count[9:3] == 7'h02) begin
				next_st.frame.arg1 = next_st.shift;
			end
			if (next_st.frame.nbytes != NBYTES_LIMIT) begin
				next_st.frame.nbytes = next_st.frame.nbytes + 6'h01;
			end
		end
	end

	// Frame contents are left as they are after the frame so that the
	// system side can read them once the select has been synchronised.
	always_ff @(posedge i_sclk) begin
		st <= next_st;
	end

	always_comb begin
		out_byte = i_snapshot.live;
		out_valid = 1'b0;
		if (st.frame.opcode == OP_READ_STATUS_ONE &&
				bit_count >= 10'h008) begin
			out_valid = 1'b1;
		end else if (st.frame.opcode == OP_READ_ANY &&
				bit_count >= 10'h010) begin
			out_valid = 1'b1;
			if (st.frame.arg0 != ANY_REG_VOL_ADDR) begin
				out_byte = i_snapshot.defaults;
			end
		end
	end

	always_ff @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			o_miso <= 1'b0;
			o_miso_oe <= 1'b0;
		end else begin
			o_miso <= out_byte[3'h7 - bit_count[2:0]];
			o_miso_oe <= out_valid;
		end
	end

	assign o_frame = st.frame;

endmodule

// File: logic/fspr_status_regs.sv
module fspr_status_regs #(
	parameter bit SMALL_VARIANT = 1'b0,
	parameter bit LATCH_DEFAULT = 1'b0,
	parameter bit BUSY_DEFAULT  = 1'b0
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	input  wire logic       i_sclk,
	input  wire logic       i_cs_n,
	input  wire logic       i_mosi,
	input  wire logic       i_write_protect_n,
	input  wire logic       i_hw_reset_n,
	input  wire logic       i_quad_io_mode,
	input  wire logic       i_quad_peripheral_mode,
	input  wire logic       i_array_done,
	input  wire logic       i_program_fail,
	input  wire logic       i_erase_fail,
	output logic            o_miso,
	output logic            o_miso_oe,
	output logic            o_array_start,
	output logic [7:0]      o_array_opcode,
	output logic            o_suspend,
	output logic [7:0]      o_status_one_volatile,
	output logic            o_regs_locked,
	output logic            o_protect_from_bottom,
	output logic            o_sector_granularity,
	output logic [3:0]      o_block_protect_level
);
	import fspr_pkg::*;

	localparam int WR_CYC = REG_WRITE_CYCLES;

	fspr_sys_type   st;
	fspr_sys_type   next_st;
	fspr_frame_type frame;
	logic           frame_end;
	logic           busy;
	logic           wp_internal;
	logic           locked_now;
	logic [7:0]     op;
	logic           soft_reset;
	logic           reg_write;
	logic           wr_nv;
	logic [7:0]     wr_data;
	fspr_prot_type  wr_prot;

	function automatic logic [7:0] to_byte(input fspr_prot_type p,
			input logic write_enable_latch, input logic op_in_progress);
		logic [7:0] b;
		b = 8'h00;
		b[LOCK_POS] = p.lock;
		b[LATCH_POS] = write_enable_latch;
		b[BUSY_POS] = op_in_progress;
		if (SMALL_VARIANT) begin
			b[SMALL_GRAN_POS] = p.granularity;
			b[SMALL_BOTTOM_POS] = p.bottom;
			b[LEVEL_LSB +: 3] = p.level[2:0];
		end else begin
			b[BOTTOM_POS] = p.bottom;
			b[LEVEL_LSB +: 4] = p.level;
		end
		return b;
	endfunction

	function automatic fspr_prot_type from_byte(input logic [7:0] b);
		fspr_prot_type p;
		p.lock = b[LOCK_POS];
		if (SMALL_VARIANT) begin
			p.granularity = b[SMALL_GRAN_POS];
			p.bottom = b[SMALL_BOTTOM_POS];
			p.level = {1'b0, b[LEVEL_LSB +: 3]};
		end else begin
			p.granularity = 1'b0;
			p.bottom = b[BOTTOM_POS];
			p.level = b[LEVEL_LSB +: 4];
		end
		return p;
	endfunction

	function automatic logic is_array_op(input logic [7:0] code);
		return code == OP_PROGRAM || code == OP_ERASE_SECTOR ||
			code == OP_ERASE_BLOCK || code == OP_ERASE_CHIP;
	endfunction

	fspr_link_shifter u_link (
		.i_sclk     (i_sclk),
		.i_cs_n     (i_cs_n),
		.i_mosi     (i_mosi),
		.i_snapshot (st.snap),
		.o_frame    (frame),
		.o_miso     (o_miso),
		.o_miso_oe  (o_miso_oe)
	);

	// Frame fields are only sampled after the synchronised select has
	// risen; by then the serial side has stopped changing them.
	assign frame_end = st.cs_sync[1] & ~st.cs_prev;
	assign op = frame.opcode;
	assign busy = st.mode != FSPR_IDLE;
	// While a quad mode is active the pin carries data line 2.
	assign wp_internal = st.wp_sync[1] | i_quad_io_mode |
		i_quad_peripheral_mode;
	assign locked_now = st.vol.lock & ~wp_internal;

	always_comb begin
		next_st = st;
		next_st.cs_sync = {st.cs_sync[0], i_cs_n};
		next_st.wp_sync = {st.wp_sync[0], i_write_protect_n};
		next_st.hw_sync = {st.hw_sync[0], i_hw_reset_n};
		next_st.cs_prev = st.cs_sync[1];
		next_st.hw_prev = st.hw_sync[1];
		next_st.locked = locked_now;
		next_st.array_start = 1'b0;
		next_st.suspend = 1'b0;
		soft_reset = 1'b0;
		reg_write = 1'b0;
		wr_nv = 1'b0;
		wr_data = 8'h00;
		wr_prot = '0;

		case (st.mode)
			FSPR_REG_WRITE: begin
				if (st.wait_cnt == 16'h0000) begin
					next_st.mode = FSPR_IDLE;
					next_st.write_enable_latch = 1'b0;
				end else begin
					next_st.wait_cnt = st.wait_cnt - 16'h0001;
				end
			end
			FSPR_ARRAY_OP: begin
				if (i_program_fail || i_erase_fail) begin
					// The latch is left set after a failure.
					next_st.mode = FSPR_FAILED;
				end else if (i_array_done) begin
					next_st.mode = FSPR_IDLE;
					next_st.write_enable_latch = 1'b0;
				end
			end
			FSPR_FAILED: begin
				next_st.mode = FSPR_FAILED;
			end
			FSPR_IDLE: begin
				next_st.mode = FSPR_IDLE;
			end
			default: begin
				next_st.mode = FSPR_IDLE;
			end
		endcase

		if (frame_end && frame.nbytes != 6'h00) begin
			next_st.reset_armed = 1'b0;
			case (op)
				OP_RESET_ARM: begin
					next_st.reset_armed = 1'b1;
				end
				OP_RESET_EXEC: begin
					if (st.reset_armed) begin
						soft_reset = 1'b1;
					end
				end
				OP_CLEAR_STATUS: begin
					// Clearing status during a running operation would
					// strand the array, so it only acts when idle or failed.
					if (st.mode == FSPR_FAILED || !busy) begin
						next_st.mode = FSPR_IDLE;
						next_st.write_enable_latch = 1'b0;
					end
				end
				OP_SUSPEND: begin
					if (st.mode == FSPR_ARRAY_OP) begin
						next_st.suspend = 1'b1;
					end
				end
				OP_SET_LATCH, OP_SET_LATCH_VOL: begin
					if (!busy) begin
						next_st.write_enable_latch = 1'b1;
						next_st.vol_target = op == OP_SET_LATCH_VOL;
					end
				end
				OP_CLEAR_LATCH: begin
					if (!busy) begin
						next_st.write_enable_latch = 1'b0;
						next_st.vol_target = 1'b0;
					end
				end
				OP_WRITE_REGS: begin
					if (!busy && frame.nbytes >= 6'h02) begin
						reg_write = 1'b1;
						wr_data = frame.arg0;
						wr_nv = ~st.vol_target;
					end
				end
				OP_WRITE_ANY: begin
					// Only the two status copies are decoded here; other
					// addresses are refused without looking at the pin.
					if (!busy && frame.nbytes >= 6'h03) begin
						reg_write = frame.arg0 == ANY_REG_NV_ADDR ||
							frame.arg0 == ANY_REG_VOL_ADDR;
						wr_data = frame.arg1;
						wr_nv = frame.arg0 == ANY_REG_NV_ADDR;
					end
				end
				default: begin
					if (!busy && st.write_enable_latch && is_array_op(op)) begin
						next_st.array_start = 1'b1;
						next_st.array_opcode = op;
						next_st.mode = FSPR_ARRAY_OP;
					end
				end
			endcase
		end

		// The data bits at the latch and busy positions are dropped, so a
		// register write can never move the latch itself.
		if (reg_write && st.write_enable_latch && !locked_now) begin
			wr_prot = from_byte(wr_data);
			next_st.vol = wr_prot;
			if (wr_nv) begin
				next_st.nv = wr_prot;
			end
			next_st.vol_target = 1'b0;
			next_st.mode = FSPR_REG_WRITE;
			next_st.wait_cnt = 16'(WR_CYC);
		end

		// A reset does not stop an array operation already handed over;
		// the array controller sees its own reset for that.
		if (soft_reset || !st.hw_sync[1]) begin
			next_st.vol = st.nv;
			next_st.write_enable_latch = LATCH_DEFAULT;
			next_st.mode = FSPR_IDLE;
			next_st.wait_cnt = 16'h0000;
			next_st.vol_target = 1'b0;
			next_st.reset_armed = 1'b0;
		end

		// The link reads this copy. It is only refreshed while the
		// synchronised select is high, so it stands still for the whole
		// frame and has settled long before the first read bit leaves.
		if (st.cs_sync[1]) begin
			next_st.snap.live = to_byte(next_st.vol, next_st.write_enable_latch,
				next_st.mode != FSPR_IDLE);
			next_st.snap.defaults = to_byte(next_st.nv, LATCH_DEFAULT,
				BUSY_DEFAULT);
		end

		// Power-on: factory defaults are all zero apart from the latch
		// and busy defaults, which are fixed at build time.
		if (i_reset) begin
			next_st = '0;
			next_st.cs_sync = 2'b11;
			next_st.wp_sync = 2'b11;
			next_st.hw_sync = 2'b11;
			next_st.cs_prev = 1'b1;
			next_st.hw_prev = 1'b1;
			next_st.write_enable_latch = LATCH_DEFAULT;
			next_st.mode = FSPR_IDLE;
			next_st.snap.live = to_byte('0, LATCH_DEFAULT, 1'b0);
			next_st.snap.defaults = to_byte('0, LATCH_DEFAULT,
				BUSY_DEFAULT);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		st <= next_st;
	end

	// The status output is the frozen link copy, so it lags by nothing
	// outside a frame but holds still while a frame is running.
	assign o_status_one_volatile = st.snap.live;
	assign o_array_start = st.array_start;
	assign o_array_opcode = st.array_opcode;
	assign o_suspend = st.suspend;
	assign o_regs_locked = st.locked;
	assign o_protect_from_bottom = st.vol.bottom;
	assign o_sector_granularity = st.vol.granularity;
	assign o_block_protect_level = st.vol.level;

	// Watched state belongs to the system clock domain, apart from the frame opcode held on the serial side.
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_array_start;
		st.array_start;
	endsequence

	sequence s_write_end;
		st.mode == FSPR_REG_WRITE && st.wait_cnt == 16'h0000 &&
			!soft_reset && st.hw_sync[1];
	endsequence

	a_start_needs_latch: assert property (
		s_array_start |-> $past(st.write_enable_latch))
		else $error("array operation started without the latch");

	a_write_end_clears: assert property (
		s_write_end |=> !st.write_enable_latch)
		else $error("latch still set after a register write");

	a_write_keeps_latch: assert property (
		st.mode == FSPR_REG_WRITE && st.wait_cnt != 16'h0000 &&
			!soft_reset && st.hw_sync[1] |=> $stable(st.write_enable_latch))
		else $error("latch moved during a register write");

	a_lock_blocks_write: assert property (
		locked_now && !soft_reset && st.hw_sync[1] |=> $stable(st.vol))
		else $error("protection changed while registers locked");

	a_fail_holds_busy: assert property (
		st.mode == FSPR_FAILED && !soft_reset && st.hw_sync[1] &&
			!(frame_end && op == OP_CLEAR_STATUS) |=>
			st.mode == FSPR_FAILED)
		else $error("failed state left without clear status");

	a_suspend_in_array: assert property (
		st.suspend |-> $past(st.mode) == FSPR_ARRAY_OP)
		else $error("suspend issued outside an array operation");

	a_quad_unlocks: assert property (
		i_quad_io_mode || i_quad_peripheral_mode |-> !locked_now)
		else $error("register lock active in a quad mode");

	a_busy_refuses_latch: assert property (
		st.mode == FSPR_FAILED && frame_end && op == OP_SET_LATCH &&
			!soft_reset && st.hw_sync[1] |=> $stable(st.write_enable_latch))
		else $error("latch command taken while busy");

endmodule

// File: tb/fspr_host_model.sv
// Host side of the serial link: mode 0, most significant bit first.
// The serial clock stands still between frames, as a real host does.
module fspr_host_model (
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_mosi,
	input  wire logic i_miso
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] rx;

	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
		rx = 8'h00;
	end

	// Sends the leading nbits of a left-aligned frame at an 80 ns period.
	task automatic send(input logic [23:0] data, input int nbits);
		int k;
		#3 o_cs_n = 1'b0;
		for (k = 23; k > 23 - nbits; k--) begin
			o_mosi = data[k];
			#40 o_sclk = 1'b1;
			rx = {rx[6:0], i_miso};
			#40 o_sclk = 1'b0;
		end
		#40 o_cs_n = 1'b1;
		// A released data line must not keep showing the last bit.
		o_mosi = ~o_mosi;
		#200;
	endtask
endmodule

// File: tb/fspr_status_regs_test.sv
module fspr_status_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	import fspr_pkg::*;

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
	err_total++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
	end end

	localparam bit LATCH_D = 1'b0;

	logic       sys_clk = 1'b0;
	logic       reset   = 1'b1;
	logic       wp_n    = 1'b1;
	logic       quad_io_mode     = 1'b0;
	logic       done    = 1'b0;
	logic       pfail   = 1'b0;
	wire logic  sclk, cs_n, mosi, miso, start;
	wire logic  [7:0] opc, sr1;
	wire logic  [3:0] level;
	wire logic  bottom;
	int         err_total = 0;
	int         checks_done = 0;
	int         starts = 0;

	fspr_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
		.i_miso(miso));

	fspr_status_regs #(.LATCH_DEFAULT(LATCH_D)) dut (
		.i_sys_clk(sys_clk), .i_reset(reset), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_mosi(mosi), .i_write_protect_n(wp_n),
		.i_hw_reset_n(1'b1), .i_quad_io_mode(quad_io_mode),
		.i_quad_peripheral_mode(1'b0), .i_array_done(done),
		.i_program_fail(pfail), .i_erase_fail(1'b0), .o_miso(miso),
		.o_miso_oe(), .o_array_start(start), .o_array_opcode(opc),
		.o_suspend(), .o_status_one_volatile(sr1), .o_regs_locked(),
		.o_protect_from_bottom(bottom), .o_sector_granularity(),
		.o_block_protect_level(level));

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		if (start === 1'b1)
			starts <= starts + 1;
	end

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Samples on the falling edge so that register updates have landed.
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic wait_idle();
		int k;
		for (k = 0; k < 400 && sr1[BUSY_POS] !== 1'b0; k++)
			tick(1);
		if (k == 400) begin
			err_total++;
			$display("[FAIL] busy expected 0 seen 1");
			tally_and_finish();
		end
	endtask

	// The program command stays busy until the array answers, so no wait there.
	task automatic wr(input logic [7:0] op, input logic [15:0] arg,
			input int nbits);
		host.send({op, arg}, nbits);
		tick(2);
		if (op != OP_PROGRAM)
			wait_idle();
	endtask

	initial begin
		tick(20);
		@(posedge sys_clk) reset <= 1'b0;
		tick(2);
		`CHK("status after reset", 8'h00, sr1)
		wr(OP_SET_LATCH, 16'h0000, 8);
		`CHK("latch set", 1'b1, sr1[LATCH_POS])
		wr(OP_CLEAR_LATCH, 16'h0000, 8);
		`CHK("latch cleared", 1'b0, sr1[LATCH_POS])
		wr(OP_SET_LATCH, 16'h0000, 8);
		@(posedge sys_clk) reset <= 1'b1;
		tick(3);
		@(posedge sys_clk) reset <= 1'b0;
		tick(2);
		`CHK("latch after reset", LATCH_D, sr1[LATCH_POS])
		wr(OP_WRITE_REGS, 16'h9600, 16);
		`CHK("write without latch", 8'h00, sr1)
		wr(OP_SET_LATCH, 16'h0000, 8);
		wr(OP_WRITE_REGS, 16'h9600, 16);
		`CHK("write with latch", 8'h94, sr1)
		`CHK("protect level", 4'h5, level)
		@(posedge sys_clk) wp_n <= 1'b0;
		wr(OP_SET_LATCH, 16'h0000, 8);
		wr(OP_WRITE_REGS, 16'h0000, 16);
		`CHK("locked write", 8'h96, sr1)
		@(posedge sys_clk) quad_io_mode <= 1'b1;
		wr(OP_WRITE_REGS, 16'h4000, 16);
		`CHK("quad write", 8'h40, sr1)
		`CHK("bottom flag", 1'b1, bottom)
		@(posedge sys_clk) quad_io_mode <= 1'b0;
		wr(OP_SET_LATCH, 16'h0000, 8);
		wr(OP_WRITE_REGS, 16'h0800, 16);
		`CHK("unlocked write", 8'h08, sr1)
		`CHK("top flag", 1'b0, bottom)
		wr(OP_PROGRAM, 16'h0000, 24);
		`CHK("program refused", 0, starts)
		wr(OP_SET_LATCH, 16'h0000, 8);
		wr(OP_PROGRAM, 16'h0000, 24);
		`CHK("program started", 1, starts)
		`CHK("array opcode", OP_PROGRAM, opc)
		host.send({OP_CLEAR_LATCH, 16'h0000}, 8);
		tick(2);
		`CHK("busy ignores clear", 8'h0B, sr1)
		@(posedge sys_clk) done <= 1'b1;
		@(posedge sys_clk) done <= 1'b0;
		tick(2);
		`CHK("program done", 8'h08, sr1)
		wr(OP_SET_LATCH, 16'h0000, 8);
		wr(OP_PROGRAM, 16'h0000, 24);
		@(posedge sys_clk) begin
			pfail <= 1'b1;
			done <= 1'b1;
		end
		@(posedge sys_clk) begin
			pfail <= 1'b0;
			done <= 1'b0;
		end
		tick(20);
		`CHK("busy after fail", 1'b1, sr1[BUSY_POS])
		host.send({OP_READ_STATUS_ONE, 16'h0000}, 16);
		`CHK("status read on link", 8'h0B, host.rx)
		wr(OP_CLEAR_STATUS, 16'h0000, 8);
		`CHK("cleared status", 8'h08, sr1)
		host.send({OP_READ_ANY, ANY_REG_NV_ADDR, 8'h00}, 24);
		`CHK("defaults read", 8'h08, host.rx)
		tally_and_finish();
	end
endmodule
